// ==== meter_pkg.sv ====
package meter_pkg;

  // Data and register port widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Clock rate and key hold timing
  localparam int CLK_FREQ_HZ     = 10_000_000;
  localparam int KEY_HOLD_MS     = 3000;
  localparam int KEY_HOLD_CYCLES = KEY_HOLD_MS * (CLK_FREQ_HZ / 1000);

  // Linearization table shape
  localparam int LIN_SEGMENTS = 10;
  localparam int LIN_POINTS   = LIN_SEGMENTS + 1;

  // Register offsets
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_SP_ONE       = 8'h01;
  localparam logic [7:0] REG_SP_TWO       = 8'h02;
  localparam logic [7:0] REG_REFERENCE    = 8'h03;
  localparam logic [7:0] REG_OFFSET       = 8'h04;
  localparam logic [7:0] REG_STATUS       = 8'h05;
  localparam logic [7:0] REG_PV           = 8'h06;
  localparam logic [7:0] REG_MAXIMUM      = 8'h07;
  localparam logic [7:0] REG_MINIMUM      = 8'h08;
  localparam logic [7:0] REG_LIN_IN_BASE  = 8'h10;
  localparam logic [7:0] REG_LIN_OUT_BASE = 8'h20;

  // Control register fields
  localparam int CTRL_FUNC_LSB  = 0;   // 3 bits per channel, channel 1 at 0, channel 2 at 3
  localparam int CTRL_FUNC_W    = 3;
  localparam int CTRL_IBLK_LSB  = 6;   // Initial blocking enable, one bit per channel
  localparam int CTRL_LINEAR    = 8;   // Linear current or voltage input selected
  localparam int CTRL_LIN_EN    = 9;   // Custom linearization enabled

  // Status register fields
  localparam int STAT_ALARM_LSB   = 0;
  localparam int STAT_FAULT       = 2;
  localparam int STAT_VIEW_MAX    = 3;
  localparam int STAT_VIEW_MIN    = 4;
  localparam int STAT_BLOCKED_LSB = 5;
  localparam int STAT_EXT_VALID   = 7;

  // Reset values
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // Alarm functions
  typedef enum logic [2:0] {
    FUNC_OFF          = 3'h0,
    FUNC_ABS_LOW      = 3'h1,
    FUNC_ABS_HIGH     = 3'h2,
    FUNC_DIFF_BAND    = 3'h3,
    FUNC_DIFF_LOW     = 3'h4,
    FUNC_DIFF_HIGH    = 3'h5,
    FUNC_SENSOR_BREAK = 3'h6
  } alarm_func_t;

  // Front-panel key sequencing, Gray along idle, timing, view
  typedef enum logic [1:0] {
    KEY_IDLE   = 2'h0,
    KEY_TIMING = 2'h1,
    KEY_VIEW   = 2'h3,
    KEY_BOTH   = 2'h2
  } key_state_t;

endpackage : meter_pkg

// ==== process_alarm_and_extremes.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Two alarm channels, own setpoint, own output
// - Absolute low: value below setpoint
// - Absolute high: value above setpoint
// - Differential setpoints are deviations from reference
// - Differential low: below reference minus setpoint
// - Differential high: above reference plus setpoint
// - Sensor break function follows fault indication
// - High, band, diff-high also fire on fault once a sample has arrived
// - Initial blocking suppresses alarm present at power-up
// - Blocking lifts once condition seen false
// - No initial blocking for sensor break
// - Offset correction added to measured value
// - Track running maximum and minimum
// - Three second key hold shows extreme
// - Both keys together clear extremes
// - Extremes volatile, lost on reset
// - Ten-segment interpolated custom linearization
// - Linearization only for linear input types
module process_alarm_and_extremes #(
  parameter int KEY_HOLD_CYCLES = meter_pkg::KEY_HOLD_CYCLES  // Key hold before extreme view
) (
  // Clock and reset
  input  wire  logic                             sys_clk,
  input  wire  logic                             rst_b,
  // Register port
  input  wire  logic [meter_pkg::ADDR_W-1:0]     reg_addr,
  input  wire  logic [meter_pkg::DATA_W-1:0]     reg_wdata,
  input  wire  logic                             reg_wr,
  input  wire  logic                             reg_rd,
  output logic       [meter_pkg::DATA_W-1:0]     reg_rdata,
  // Conversion stage
  input  wire  logic [meter_pkg::DATA_W-1:0]     sample_raw,
  input  wire  logic                             sample_valid,
  input  wire  logic                             sensor_fault,
  // Front-panel keys, asynchronous pins
  input  wire  logic                             maximum_view_key,
  input  wire  logic                             minimum_view_key,
  // Alarm lines and display
  output logic                                   first_alarm_output,
  output logic                                   second_alarm_output,
  output logic       [meter_pkg::DATA_W-1:0]     display_value,
  output logic                                   display_shows_max,
  output logic                                   display_shows_min
);
  import meter_pkg::*;

  // Whole block state
  typedef struct packed {
    logic [15:0]                  ctrl;        // Functions, blocking, input kind
    logic [1:0][15:0]             sp;          // Per-channel setpoints
    logic [15:0]                  ref_v;       // Shared alarm reference
    logic [15:0]                  offset;      // Offset correction
    logic [LIN_POINTS-1:0][15:0]  inp;         // Linearization input points
    logic [LIN_POINTS-1:0][15:0]  dup;         // Linearization display points
    logic [15:0]                  pv;          // Corrected process value
    logic                         pv_valid;    // A sample has arrived
    logic [15:0]                  max_v;       // Running maximum
    logic [15:0]                  min_v;       // Running minimum
    logic                         ext_valid;   // Extremes hold data
    logic                         pending;     // Power-up evaluation still due
    logic [1:0]                   blocked;     // Initial blocking active
    logic [1:0]                   alarm;       // Alarm outputs
    logic                         kmax_s1;     // Key synchronisers
    logic                         kmax_s2;
    logic                         kmin_s1;
    logic                         kmin_s2;
    key_state_t                   key_st;      // Key sequencer
    logic [31:0]                  hold_cnt;    // Key hold counter
    logic                         view_max;    // Display shows maximum
    logic                         view_min;    // Display shows minimum
    logic [15:0]                  display;     // Display value
    logic [15:0]                  rdata;       // Read data
  } state_t;

  state_t      s;          // Registered state
  state_t      next_s;     // Next state
  logic [1:0]  rst_sync;   // Reset release synchroniser
  logic        rst_n;      // Synchronised reset

  // Saturate a wide signed value to the data width
  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > 36'sh0_0000_7FFF) begin
      r = 16'h7FFF;
    end else if (v < -36'sh0_0000_8000) begin
      r = 16'h8000;
    end
    return r;
  endfunction : sat16

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Next-state logic
  always_comb begin
    logic signed [16:0] dx;        // Input above segment start
    logic signed [16:0] dy;        // Display span of segment
    logic signed [16:0] den;       // Input span of segment
    logic signed [33:0] prod;      // Scaled offset in segment
    logic signed [33:0] quo;       // Interpolated increment
    logic [15:0]        lin_val;   // Linearized value
    logic [15:0]        base;      // Value before offset
    logic [15:0]        corr;      // Corrected value
    logic signed [17:0] p18;       // Process value, widened
    logic signed [17:0] r18;       // Reference, widened
    logic signed [17:0] sp18;      // Setpoint, widened
    logic               cond;      // Channel alarm condition
    logic               kmax;      // Synchronised maximum key
    logic               kmin;      // Synchronised minimum key
    logic               clear_req; // Clear extremes this cycle
    alarm_func_t        func;      // Channel function
    int                 seg;       // Active segment
    int                 idx;       // Table index from address
    dx        = '0;
    dy        = '0;
    den       = '0;
    prod      = '0;
    quo       = '0;
    lin_val   = '0;
    base      = '0;
    corr      = '0;
    p18       = '0;
    r18       = '0;
    sp18      = '0;
    cond      = 1'b0;
    clear_req = 1'b0;
    func      = FUNC_OFF;
    seg       = 0;
    idx       = int'(reg_addr[3:0]);
    next_s    = s;
    next_s.rdata = 16'h0000;

    // Key pins pass two flip-flops
    next_s.kmax_s1 = maximum_view_key;
    next_s.kmax_s2 = s.kmax_s1;
    next_s.kmin_s1 = minimum_view_key;
    next_s.kmin_s2 = s.kmin_s1;
    kmax = s.kmax_s2;
    kmin = s.kmin_s2;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:      next_s.ctrl   = reg_wdata;
        REG_SP_ONE:    next_s.sp[0]  = reg_wdata;
        REG_SP_TWO:    next_s.sp[1]  = reg_wdata;
        REG_REFERENCE: next_s.ref_v  = reg_wdata;
        REG_OFFSET:    next_s.offset = reg_wdata;
        default: begin
          // Table entries, other addresses ignored
          if (reg_addr[7:4] == REG_LIN_IN_BASE[7:4] && idx < LIN_POINTS) begin
            next_s.inp[idx] = reg_wdata;
          end else if (reg_addr[7:4] == REG_LIN_OUT_BASE[7:4] && idx < LIN_POINTS) begin
            next_s.dup[idx] = reg_wdata;
          end
        end
      endcase
    end

    // Register reads, data valid the next cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:      next_s.rdata = s.ctrl;
        REG_SP_ONE:    next_s.rdata = s.sp[0];
        REG_SP_TWO:    next_s.rdata = s.sp[1];
        REG_REFERENCE: next_s.rdata = s.ref_v;
        REG_OFFSET:    next_s.rdata = s.offset;
        REG_STATUS: begin
          next_s.rdata[STAT_ALARM_LSB +: 2]   = s.alarm;
          next_s.rdata[STAT_FAULT]            = sensor_fault;
          next_s.rdata[STAT_VIEW_MAX]         = s.view_max;
          next_s.rdata[STAT_VIEW_MIN]         = s.view_min;
          next_s.rdata[STAT_BLOCKED_LSB +: 2] = s.blocked;
          next_s.rdata[STAT_EXT_VALID]        = s.ext_valid;
        end
        REG_PV:        next_s.rdata = s.pv;
        REG_MAXIMUM:   next_s.rdata = s.max_v;
        REG_MINIMUM:   next_s.rdata = s.min_v;
        default: begin
          // Table entries, unmapped reads as zero
          if (reg_addr[7:4] == REG_LIN_IN_BASE[7:4] && idx < LIN_POINTS) begin
            next_s.rdata = s.inp[idx];
          end else if (reg_addr[7:4] == REG_LIN_OUT_BASE[7:4] && idx < LIN_POINTS) begin
            next_s.rdata = s.dup[idx];
          end
        end
      endcase
    end

    // Segment search over the rising breakpoints
    for (int k = 1; k < LIN_SEGMENTS; k++) begin
      if ($signed(sample_raw) >= $signed(s.inp[k])) begin
        seg = k;
      end
    end
    // Interpolate inside the segment, ends extrapolate
    dx  = {sample_raw[15], sample_raw} - {s.inp[seg][15], s.inp[seg]};
    dy  = {s.dup[seg + 1][15], s.dup[seg + 1]} - {s.dup[seg][15], s.dup[seg]};
    den = {s.inp[seg + 1][15], s.inp[seg + 1]} - {s.inp[seg][15], s.inp[seg]};
    // Guard against a flat or falling table
    if (den[16] || den == 17'h00000) begin
      den = 17'h00001;
    end
    prod    = dx * dy;
    quo     = prod / 34'(den);
    lin_val = sat16(36'(quo) + 36'($signed(s.dup[seg])));
    // Thermocouple and RTD inputs bypass the table
    base = (s.ctrl[CTRL_LIN_EN] && s.ctrl[CTRL_LINEAR]) ? lin_val : sample_raw;
    corr = sat16(36'($signed(base)) + 36'($signed(s.offset)));

    // New sample taken
    if (sample_valid) begin
      next_s.pv       = corr;
      next_s.pv_valid = 1'b1;
    end

    // Key sequencing
    unique case (s.key_st)
      KEY_IDLE: begin
        next_s.hold_cnt = 32'h0000_0000;
        if (kmax && kmin) begin
          clear_req     = 1'b1;
          next_s.key_st = KEY_BOTH;
        end else if (kmax || kmin) begin
          next_s.key_st = KEY_TIMING;
        end
      end
      KEY_TIMING: begin
        if (kmax && kmin) begin
          clear_req     = 1'b1;
          next_s.key_st = KEY_BOTH;
        end else if (!kmax && !kmin) begin
          next_s.key_st = KEY_IDLE;
        end else if (s.hold_cnt >= 32'(KEY_HOLD_CYCLES - 1)) begin
          // Held long enough, show the chosen extreme
          next_s.key_st   = KEY_VIEW;
          next_s.view_max = kmax;
          next_s.view_min = kmin;
        end else begin
          next_s.hold_cnt = s.hold_cnt + 32'h0000_0001;
        end
      end
      KEY_VIEW: begin
        if (kmax && kmin) begin
          clear_req       = 1'b1;
          next_s.key_st   = KEY_BOTH;
          next_s.view_max = 1'b0;
          next_s.view_min = 1'b0;
        end else if (!kmax && !kmin) begin
          next_s.key_st   = KEY_IDLE;
          next_s.view_max = 1'b0;
          next_s.view_min = 1'b0;
        end
      end
      KEY_BOTH: begin
        // Wait for both keys released
        next_s.hold_cnt = 32'h0000_0000;
        if (!kmax && !kmin) begin
          next_s.key_st = KEY_IDLE;
        end
      end
    endcase

    // Running extremes, skipped while the sensor is faulty
    if (clear_req) begin
      next_s.ext_valid = 1'b0;
    end
    // A sample in the clearing cycle opens the new period
    if (sample_valid && !sensor_fault) begin
      if (!next_s.ext_valid) begin
        next_s.max_v     = corr;
        next_s.min_v     = corr;
        next_s.ext_valid = 1'b1;
      end else begin
        if ($signed(corr) > $signed(s.max_v)) begin
          next_s.max_v = corr;
        end
        if ($signed(corr) < $signed(s.min_v)) begin
          next_s.min_v = corr;
        end
      end
    end

    // Alarm channels
    p18 = {{2{s.pv[15]}}, s.pv};
    r18 = {{2{s.ref_v[15]}}, s.ref_v};
    for (int i = 0; i < 2; i++) begin
      func = alarm_func_t'(s.ctrl[CTRL_FUNC_LSB + CTRL_FUNC_W * i +: CTRL_FUNC_W]);
      sp18 = {{2{s.sp[i][15]}}, s.sp[i]};
      unique case (func)
        FUNC_OFF: begin
          cond = 1'b0;
        end
        FUNC_ABS_LOW: begin
          cond = s.pv_valid && ($signed(s.pv) < $signed(s.sp[i]));
        end
        FUNC_ABS_HIGH: begin
          cond = s.pv_valid && (($signed(s.pv) > $signed(s.sp[i])) || sensor_fault);
        end
        FUNC_DIFF_BAND: begin
          if (!sp18[17]) begin
            cond = (p18 < r18 - sp18) || (p18 > r18 + sp18);
          end else begin
            cond = (p18 > r18 + sp18) && (p18 < r18 - sp18);
          end
          cond = s.pv_valid && (cond || sensor_fault);
        end
        FUNC_DIFF_LOW: begin
          cond = s.pv_valid && (p18 < r18 - sp18);
        end
        FUNC_DIFF_HIGH: begin
          cond = s.pv_valid && ((p18 > r18 + sp18) || sensor_fault);
        end
        FUNC_SENSOR_BREAK: begin
          cond = sensor_fault;
        end
        default: begin
          cond = 1'b0;
        end
      endcase

      // Initial blocking decided on the first evaluated sample
      if (s.pending && s.pv_valid) begin
        next_s.blocked[i] = s.ctrl[CTRL_IBLK_LSB + i] && cond && (func != FUNC_SENSOR_BREAK);
      end else if (s.blocked[i] && (!cond || func == FUNC_SENSOR_BREAK)) begin
        next_s.blocked[i] = 1'b0;
      end
      next_s.alarm[i] = cond && !next_s.blocked[i];
    end
    if (s.pv_valid) begin
      next_s.pending = 1'b0;
    end

    // Display selection
    if (next_s.view_max) begin
      next_s.display = next_s.max_v;
    end else if (next_s.view_min) begin
      next_s.display = next_s.min_v;
    end else begin
      next_s.display = next_s.pv;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.ctrl    <= CTRL_RESET;
      s.offset  <= VALUE_RESET;
      s.pending <= 1'b1;
      s.key_st  <= KEY_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign reg_rdata           = s.rdata;
  assign first_alarm_output  = s.alarm[0];
  assign second_alarm_output = s.alarm[1];
  assign display_value       = s.display;
  assign display_shows_max   = s.view_max;
  assign display_shows_min   = s.view_min;

endmodule : process_alarm_and_extremes

`default_nettype wire

// ==== alarm_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port-level alarm and key checks
module alarm_checker_sva #(
  parameter int KEY_HOLD_CYCLES = meter_pkg::KEY_HOLD_CYCLES  // Hold before view
) (
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  // Register writes
  input wire logic [meter_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [meter_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                         reg_wr,
  // Conversion stage and keys
  input wire logic                         sample_valid,
  input wire logic                         sensor_fault,
  input wire logic                         maximum_view_key,
  // Alarms and display
  input wire logic                         first_alarm_output,
  input wire logic                         second_alarm_output,
  input wire logic [meter_pkg::DATA_W-1:0] display_value,
  input wire logic                         display_shows_max,
  input wire logic                         display_shows_min
);
  import meter_pkg::*;

  logic [15:0] ctrl;   // Shadow control word
  logic [15:0] sp1;    // Shadow setpoint one
  logic [15:0] sp2;    // Shadow setpoint two
  logic [1:0]  quiet;  // Cycles since a write
  logic        seen;   // A sample has arrived
  logic [31:0] hold;   // Max key held cycles

  // Shadow of configuration and key timing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl  <= 16'h0000;
      sp1   <= 16'h0000;
      sp2   <= 16'h0000;
      quiet <= 2'h0;
      seen  <= 1'b0;
      hold  <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) ctrl <= reg_wdata;
      if (reg_wr && reg_addr == REG_SP_ONE) sp1 <= reg_wdata;
      if (reg_wr && reg_addr == REG_SP_TWO) sp2 <= reg_wdata;
      quiet <= reg_wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      seen  <= seen | sample_valid;
      hold  <= maximum_view_key ? hold + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Settled process value, no fault, no view
  sequence calm;
    (quiet == 2'h3 && seen && !sensor_fault && !display_shows_max && !display_shows_min
     && $stable(display_value))[*3];
  endsequence

  AST_OFF_ONE: assert property (quiet == 2'h3 && ctrl[2:0] inside {3'h0, 3'h7} |-> !first_alarm_output)
    else $error("Alarm one active while off");
  AST_OFF_TWO: assert property (quiet == 2'h3 && ctrl[5:3] inside {3'h0, 3'h7} |-> !second_alarm_output)
    else $error("Alarm two active while off");
  AST_BREAK: assert property ((quiet == 2'h3 && ctrl[2:0] == FUNC_SENSOR_BREAK && sensor_fault)[*3]
    |-> first_alarm_output) else $error("Sensor break alarm missing");
  AST_BREAK_CLR: assert property ((quiet == 2'h3 && ctrl[2:0] == FUNC_SENSOR_BREAK && !sensor_fault)[*3]
    |-> !first_alarm_output) else $error("Sensor break alarm without fault");
  AST_FAULT_FORCE: assert property ((quiet == 2'h3 && seen && !ctrl[7]
    && ctrl[5:3] inside {3'h2, 3'h3, 3'h5} && sensor_fault)[*3] |-> second_alarm_output)
    else $error("Fault did not force alarm two");
  AST_LOW: assert property (calm ##0 (ctrl[2:0] == FUNC_ABS_LOW && !ctrl[6])
    |-> first_alarm_output == ($signed(display_value) < $signed(sp1))) else $error("Low alarm wrong");
  AST_HIGH: assert property (calm ##0 (ctrl[5:3] == FUNC_ABS_HIGH && !ctrl[7])
    |-> second_alarm_output == ($signed(display_value) > $signed(sp2))) else $error("High alarm wrong");
  AST_HOLD: assert property ($rose(display_shows_max) |-> hold >= KEY_HOLD_CYCLES)
    else $error("Maximum view too early");
  AST_RELEASE: assert property (!maximum_view_key[*4] |-> !display_shows_max)
    else $error("Maximum view after release");

endmodule : alarm_checker_sva

bind process_alarm_and_extremes alarm_checker_sva #(
  .KEY_HOLD_CYCLES(KEY_HOLD_CYCLES)
) u_checker (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .sample_valid(sample_valid),
  .sensor_fault(sensor_fault),
  .maximum_view_key(maximum_view_key),
  .first_alarm_output(first_alarm_output),
  .second_alarm_output(second_alarm_output),
  .display_value(display_value),
  .display_shows_max(display_shows_max),
  .display_shows_min(display_shows_min)
);

`default_nettype wire

// ==== conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Conversion stage and panel keys
module conv_model (
  // Clock
  input  wire logic        sys_clk,
  // Toward the meter
  output var  logic [15:0] sample_raw,
  output var  logic        sample_valid,
  output var  logic        sensor_fault,
  output var  logic        maximum_view_key,
  output var  logic        minimum_view_key
);
  // Idle levels
  initial begin
    sample_raw       = 16'h0000;
    sample_valid     = 1'b0;
    sensor_fault     = 1'b0;
    maximum_view_key = 1'b0;
    minimum_view_key = 1'b0;
  end

  // One sample pulse; bus scrambled once stale
  task automatic send(input logic [15:0] v, input logic f);
    @(posedge sys_clk);
    sample_raw   <= v;
    sample_valid <= 1'b1;
    sensor_fault <= f;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    sample_raw   <= ~v;
  endtask : send

  // Fault level alone
  task automatic fault(input logic f);
    @(posedge sys_clk);
    sensor_fault <= f;
  endtask : fault

  // Key pin levels
  task automatic keys(input logic mx, input logic mn);
    @(posedge sys_clk);
    maximum_view_key <= mx;
    minimum_view_key <= mn;
  endtask : keys
endmodule : conv_model

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the alarm block
module testbench;
  import meter_pkg::*;
  localparam int HOLD = 20;  // Shortened key hold

  logic        sys_clk;       // 10 MHz
  logic        rst_b;         // Reset pin
  logic [7:0]  reg_addr;      // Register port
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] sample_raw;    // Partner side
  logic        sample_valid;
  logic        sensor_fault;
  logic        mx_key;
  logic        mn_key;
  logic        alarm1;        // Outputs
  logic        alarm2;
  logic [15:0] display_value;
  logic        shows_max;
  logic        shows_min;
  int          fails;         // Mismatch count
  int          total_checks;  // Compare count
  int          seed;
  int          i, sp1, sp2, rf, off, raw, pv, fa, fb;
  logic        flt;

  process_alarm_and_extremes #(.KEY_HOLD_CYCLES(HOLD)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_raw(sample_raw),
    .sample_valid(sample_valid), .sensor_fault(sensor_fault), .maximum_view_key(mx_key),
    .minimum_view_key(mn_key), .first_alarm_output(alarm1), .second_alarm_output(alarm2),
    .display_value(display_value), .display_shows_max(shows_max), .display_shows_min(shows_min)
  );
  conv_model u_conv (
    .sys_clk(sys_clk), .sample_raw(sample_raw), .sample_valid(sample_valid),
    .sensor_fault(sensor_fault), .maximum_view_key(mx_key), .minimum_view_key(mn_key)
  );

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Expected alarm level for one channel
  function automatic logic aexp(input int f, input int pv, input int sp, input int rf, input logic flt);
    case (f)
      1: return pv < sp;
      2: return pv > sp || flt;
      3: return flt || (sp >= 0 ? (pv > rf + sp || pv < rf - sp) : (pv < rf - sp && pv > rf + sp));
      4: return pv < rf - sp;
      5: return pv > rf + sp || flt;
      6: return flt;
      default: return 1'b0;
    endcase
  endfunction : aexp

  // Expected linearized value, table point k shows k*k*10
  function automatic int lexp(input int x);
    int s;
    s = x / 100;
    return s * s * 10 + (x - s * 100) * ((s + 1) * (s + 1) * 10 - s * s * 10) / 100;
  endfunction : lexp

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read, data taken in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rchk

  task automatic smp(input int v, input logic f);
    u_conv.send(16'(v), f);
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : smp

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  task automatic do_reset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  task automatic final_report;
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    #(100 * 40000);
    fails++;
    final_report;
  end

  // Main sequence
  initial begin
    seed = 90103;
    fails = 0;
    total_checks = 0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset;
    for (i = 0; i < 9; i++) rchk(8'(i), 16'h0000);
    rchk(8'h30, 16'h0000);
    // Sensor break with blocking enabled, before any sample
    wr(REG_CTRL, 16'h0046);
    u_conv.fault(1'b1);
    wait_cyc(8);
    chk(16'(alarm1), 16'h0001);
    u_conv.fault(1'b0);
    wait_cyc(8);
    chk(16'(alarm1), 16'h0000);
    // Every function code on both channels, random levels
    for (i = 0; i < 40; i++) begin
      fa = i % 8;
      fb = (i + 3) % 8;
      sp1 = $random(seed) % 500;
      sp2 = $random(seed) % 500;
      rf = $random(seed) % 500;
      off = $random(seed) % 50;
      raw = $random(seed) % 500;
      flt = 1'($random(seed));
      wr(REG_CTRL, 16'({fb[2:0], fa[2:0]}));
      wr(REG_SP_ONE, 16'(sp1));
      wr(REG_SP_TWO, 16'(sp2));
      wr(REG_REFERENCE, 16'(rf));
      wr(REG_OFFSET, 16'(off));
      smp(raw, flt);
      pv = raw + off;
      chk(display_value, 16'(pv));
      chk(16'(alarm1), 16'(aexp(fa, pv, sp1, rf, flt)));
      chk(16'(alarm2), 16'(aexp(fb, pv, sp2, rf, flt)));
    end
    // Initial blocking after a fresh power-up
    do_reset;
    rchk(REG_MAXIMUM, 16'h0000);
    wr(REG_CTRL, 16'h00F1);
    wr(REG_SP_ONE, 16'd100);
    smp(50, 1'b1);
    chk(16'(alarm1), 16'h0000);
    chk(16'(alarm2), 16'h0001);
    rchk(REG_STATUS, 16'h0026);
    smp(150, 1'b0);
    smp(50, 1'b0);
    chk(16'(alarm1), 16'h0001);
    smp(120, 1'b0);
    rchk(REG_MAXIMUM, 16'd150);
    rchk(REG_MINIMUM, 16'd50);
    // Key views and clearing
    u_conv.keys(1'b1, 1'b0);
    wait_cyc(HOLD - 2);
    chk(16'(shows_max), 16'h0000);
    wait_cyc(10);
    chk(16'(shows_max), 16'h0001);
    chk(display_value, 16'd150);
    u_conv.keys(1'b0, 1'b0);
    wait_cyc(5);
    chk(display_value, 16'd120);
    u_conv.keys(1'b0, 1'b1);
    wait_cyc(HOLD + 8);
    chk(16'(shows_min), 16'h0001);
    chk(display_value, 16'd50);
    u_conv.keys(1'b1, 1'b1);
    wait_cyc(5);
    u_conv.keys(1'b0, 1'b0);
    wait_cyc(5);
    smp(70, 1'b0);
    rchk(REG_MAXIMUM, 16'd70);
    rchk(REG_MINIMUM, 16'd70);
    // Linearization table, breakpoints rising
    for (i = 0; i < LIN_POINTS; i++) begin
      wr(REG_LIN_IN_BASE + 8'(i), 16'(i * 100));
      wr(REG_LIN_OUT_BASE + 8'(i), 16'(i * i * 10));
    end
    wr(REG_CTRL, 16'h0300);
    for (i = 0; i < 4; i++) begin
      raw = (i == 0) ? 900 : {$random(seed)} % 1000;
      smp(raw, 1'b0);
      chk(display_value, 16'(lexp(raw)));
    end
    wr(REG_CTRL, 16'h0200);
    smp(250, 1'b0);
    chk(display_value, 16'd250);
    final_report;
  end
endmodule : testbench

`default_nettype wire
